// *** hw/rld_pkg.sv ***
// What this block does
// - Custom source side, both lane controls low: power down, nothing routed, any orientation.
// - Custom sink side puts USB on the opposite pair to the source side; both lane controls low is power down.
// - Lane control hi low, lo high: one USB port; orientation picks flipped variant.
// - Custom: hi only gives four custom channels; both high gives USB plus two.
// - Display four-lane matches assignments C/E; USB plus two lanes matches D/F.
// - Lane control hi high, orientation low: positive aux to SBU1, negative to SBU2.
// - Lane control hi high, orientation high: aux lines crossed onto SBU2 and SBU1.
// - Pin decode applies in GPIO mode; in I2C mode lane paths follow it only for field 0000/1111, mode and aux for any field.
// - Source USB unflipped: receive pair 1 from downstream, transmit pair 1 from upstream.
// - Source USB flipped: same as unflipped but on lane pair 2.
// - Source four lanes unflipped: lanes 0-3 on RX2, TX2, TX1, RX1, upstream EQ.
// - Source four lanes flipped: mirrored order RX1, TX1, TX2, RX2.
// - Swap reverses every path; each slot keeps its listed equalizer group.
// - Sink USB: pair 2 unflipped, pair 1 flipped, same directions and EQ.
// - Sink four lanes unflipped: lanes 3,2,1,0 on RX2,TX2,TX1,RX1; flip exchanges pairs.
// - Sink USB plus two: USB on pair 2, lanes 0/1 on RX1/TX1; flip exchanges.
// - Source custom unflipped: lane 1 on pair 2, lane 0 on pair 1, EQ by input.
// - Four-level inputs are sampled at reset release and held afterwards.
// - Power-up defaults to USB only; controller leaves it by pulsing lane control lo.
// - GPIO configuration when interface select reads level 0 or floating.
// - Swap reverses direction; each path keeps its upstream or downstream input EQ setting.
package rld_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int FILTER_TIME_US = 2000;
	localparam int FILTER_TICKS = (FILTER_TIME_US * 1000) / TICK_NS;
	localparam int CFG_LATCH_DELAY = 2;

	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ROUTE = 8'h08;
	localparam logic [7:0] OFS_LANES = 8'h0c;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam logic [3:0] CONTROL_RESET = 4'h0;
	localparam int STATUS_MODE_POS = 0;
	localparam int STATUS_SBU_POS = 4;
	localparam int STATUS_I2C_POS = 6;
	localparam int STATUS_VALID_POS = 7;
	localparam int STATUS_DEFAULT_POS = 8;
	localparam int ROUTE_EN_POS = 0;
	localparam int ROUTE_UP_POS = 4;
	localparam int ROUTE_DEQ_POS = 8;
	localparam int ROUTE_EQ_POS = 12;
	localparam int CONFIG_IFACE_POS = 0;
	localparam int CONFIG_UEQ_POS = 2;
	localparam int CONFIG_DEQ_POS = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	localparam logic [1:0] LEVEL_0 = 2'h0;
	localparam logic [1:0] LEVEL_R = 2'h1;
	localparam logic [1:0] LEVEL_F = 2'h2;
	localparam logic [1:0] LEVEL_1 = 2'h3;
	localparam logic [3:0] SWAP_ALL_LOW = 4'h0;
	localparam logic [3:0] SWAP_ALL_HIGH = 4'hf;

	// Lane function carried by a slot
	localparam logic [2:0] FN_NONE = 3'h0;
	localparam logic [2:0] FN_USB = 3'h1;
	localparam logic [2:0] FN_DP0 = 3'h2;
	localparam logic [2:0] FN_DP1 = 3'h3;
	localparam logic [2:0] FN_LN0 = 3'h6;
	localparam logic [2:0] FN_LN1 = 3'h7;

	typedef enum logic [3:0] {
		MODE_OFF = 4'b0001,
		MODE_USB = 4'b0010,
		MODE_ALT4 = 4'b0100,
		MODE_COMBO = 4'b1000
	} rld_mode_type;

	typedef enum logic [1:0] {
		SBU_OPEN = 2'b00,
		SBU_STRAIGHT = 2'b01,
		SBU_CROSSED = 2'b10
	} rld_sbu_type;

endpackage : rld_pkg

// *** hw/rld_low_filter.sv ***
`timescale 1ns/1ps
module rld_low_filter #(
	parameter int THRESHOLD = rld_pkg::FILTER_TICKS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Level already in the aclk domain
	input wire logic level_in,
	output logic long_low
);

	typedef struct packed {
		logic [5:0] tick_cnt;
		logic [19:0] low_cnt;
		logic long_low;
	} rld_filter_type;

	rld_filter_type s_q;
	rld_filter_type s_d;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d = s_q;
		if (s_q.tick_cnt == 6'(rld_pkg::TICK_CYCLES - 1))
			s_d.tick_cnt = 6'h00;
		else
			s_d.tick_cnt = s_q.tick_cnt + 6'h01;
		if (level_in)
		begin
			s_d.low_cnt = 20'h00000;
			s_d.long_low = 1'b0;
		end
		else if (s_q.tick_cnt == 6'(rld_pkg::TICK_CYCLES - 1) && !s_q.long_low)
		begin
			// One extra tick so a partial first tick never shortens the wait
			if (s_q.low_cnt == 20'(THRESHOLD))
				s_d.long_low = 1'b1;
			else
				s_d.low_cnt = s_q.low_cnt + 20'h00001;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign long_low = s_q.long_low;

endmodule : rld_low_filter

// *** hw/rld_lane_route_decoder.sv ***
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module rld_lane_route_decoder #(
	parameter int FILTER_TICKS = rld_pkg::FILTER_TICKS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration pins from the power delivery controller
	input wire logic side_select_hi,
	input wire logic side_select_lo,
	input wire logic lane_control_hi,
	input wire logic lane_control_lo,
	input wire logic orientation_flip,
	input wire logic path_swap,
	// Four-level inputs as resolved level codes
	input wire logic [1:0] interface_select_level,
	input wire logic [3:0] upstream_eq_setting,
	input wire logic [3:0] downstream_eq_setting,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Decoded routing, slots are RX1, TX1, RX2, TX2
	output rld_pkg::rld_mode_type mode,
	output rld_pkg::rld_sbu_type sbu_map,
	output logic [3:0] path_enable,
	output logic [3:0] path_from_upstream,
	output logic [3:0] path_eq_downstream,
	output logic [15:0] path_eq_level,
	output logic [11:0] path_function
);

	typedef struct packed {
		logic [15:0] sync1;
		logic [15:0] sync2;
		logic [1:0] cfg_wait;
		logic cfg_done;
		logic [1:0] iface_level;
		logic [3:0] ueq;
		logic [3:0] deq;
		logic ctl_lo_seen_high;
		logic usb_default;
		rld_pkg::rld_mode_type mode;
		rld_pkg::rld_sbu_type sbu;
		logic route_valid;
		logic [3:0] path_en;
		logic [3:0] path_up;
		logic [3:0] path_deq;
		logic [15:0] path_eq;
		logic [11:0] path_fn;
		logic [3:0] reverse_field;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} rld_state_type;

	rld_state_type s_q;
	rld_state_type s_d;
	logic long_low;

	// Decode temporaries
	logic side_hi;
	logic side_lo;
	logic ctl_hi;
	logic ctl_lo;
	logic orient;
	logic swp;
	logic power_down;
	logic i2c_mode;
	logic usb_pair;
	logic rev;
	logic is_tx;
	logic pair;
	logic up;
	logic eqd;
	logic en;
	logic [1:0] pos;
	logic [2:0] fn;

	////////////////////////////////////////////////////////////////////////
	rld_low_filter #(
		.THRESHOLD(FILTER_TICKS)
	) u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(s_q.sync2[12]),
		.long_low(long_low)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] read_word(input rld_state_type st,
		input logic [7:0] addr, output logic hit);
		logic [31:0] w;
		w = 32'h00000000;
		hit = 1'b1;
		case (addr)
			rld_pkg::OFS_CONTROL:
				w[3:0] = st.reverse_field;
			rld_pkg::OFS_STATUS:
			begin
				w[rld_pkg::STATUS_MODE_POS +: 4] = st.mode;
				w[rld_pkg::STATUS_SBU_POS +: 2] = st.sbu;
				w[rld_pkg::STATUS_I2C_POS] =
					(st.iface_level == rld_pkg::LEVEL_1);
				w[rld_pkg::STATUS_VALID_POS] = st.route_valid;
				w[rld_pkg::STATUS_DEFAULT_POS] = st.usb_default;
			end
			rld_pkg::OFS_ROUTE:
			begin
				w[rld_pkg::ROUTE_EN_POS +: 4] = st.path_en;
				w[rld_pkg::ROUTE_UP_POS +: 4] = st.path_up;
				w[rld_pkg::ROUTE_DEQ_POS +: 4] = st.path_deq;
				w[rld_pkg::ROUTE_EQ_POS +: 16] = st.path_eq;
			end
			rld_pkg::OFS_LANES:
				w[11:0] = st.path_fn;
			rld_pkg::OFS_CONFIG:
			begin
				w[rld_pkg::CONFIG_IFACE_POS +: 2] = st.iface_level;
				w[rld_pkg::CONFIG_UEQ_POS +: 4] = st.ueq;
				w[rld_pkg::CONFIG_DEQ_POS +: 4] = st.deq;
			end
			default:
				hit = 1'b0;
		endcase
		return w;
	endfunction : read_word

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic rd_hit;
		logic [31:0] rd_word;
		rd_hit = 1'b0;
		rd_word = 32'h00000000;
		s_d = s_q;

		// Pins cross in from the controller through two flops
		s_d.sync1 = {path_swap, orientation_flip, lane_control_lo,
			lane_control_hi, side_select_lo, side_select_hi,
			interface_select_level, upstream_eq_setting,
			downstream_eq_setting};
		s_d.sync2 = s_q.sync1;
		side_hi = s_q.sync2[10];
		side_lo = s_q.sync2[11];
		ctl_hi = s_q.sync2[12];
		ctl_lo = s_q.sync2[13];
		orient = s_q.sync2[14];
		swp = s_q.sync2[15];

		// Levels settle in the synchroniser before the one-time capture
		if (!s_q.cfg_done)
		begin
			if (s_q.cfg_wait == 2'(rld_pkg::CFG_LATCH_DELAY))
			begin
				s_d.cfg_done = 1'b1;
				s_d.iface_level = s_q.sync2[9:8];
				s_d.ueq = s_q.sync2[7:4];
				s_d.deq = s_q.sync2[3:0];
			end
			else
				s_d.cfg_wait = s_q.cfg_wait + 2'h1;
		end

		// Default USB mode ends on a low-high-low pulse of lane control lo
		if (ctl_lo)
			s_d.ctl_lo_seen_high = 1'b1;
		else if (s_q.ctl_lo_seen_high)
			s_d.usb_default = 1'b0;

		// Level R is undefined; treated as GPIO like 0 and F
		i2c_mode = (s_q.iface_level == rld_pkg::LEVEL_1);
		s_d.route_valid = !i2c_mode ||
			s_q.reverse_field == rld_pkg::SWAP_ALL_LOW ||
			s_q.reverse_field == rld_pkg::SWAP_ALL_HIGH;

		power_down = !ctl_hi && !ctl_lo;
		if (power_down && !s_q.usb_default)
			s_d.mode = rld_pkg::MODE_OFF;
		else if (!ctl_hi)
			s_d.mode = rld_pkg::MODE_USB;
		else if (!ctl_lo)
			s_d.mode = rld_pkg::MODE_ALT4;
		else
			s_d.mode = rld_pkg::MODE_COMBO;

		// Sink side puts USB on the opposite pair to the source side
		usb_pair = orient ^ side_lo;
		rev = orient ^ side_lo;
		up = 1'b0;
		eqd = 1'b0;
		en = 1'b0;
		pos = 2'h0;
		fn = rld_pkg::FN_NONE;
		is_tx = 1'b0;
		pair = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			is_tx = i[0];
			pair = i[1];
			// Display order from source unflipped: RX2, TX2, TX1, RX1
			pos = {~pair, ~(pair ^ is_tx)};
			if (rev)
				pos = 2'h3 - pos;
			en = 1'b1;
			up = is_tx;
			eqd = !is_tx;
			fn = rld_pkg::FN_USB;
			case (s_d.mode)
				rld_pkg::MODE_USB:
					en = (pair == usb_pair);
				rld_pkg::MODE_ALT4:
				begin
					if (side_hi)
						fn = (pair == !orient) ? rld_pkg::FN_LN1 :
							rld_pkg::FN_LN0;
					else
					begin
						up = 1'b1;
						eqd = 1'b0;
						fn = 3'(rld_pkg::FN_DP0 + {1'b0, pos});
					end
				end
				rld_pkg::MODE_COMBO:
				begin
					if (pair != usb_pair)
					begin
						if (side_hi)
							fn = rld_pkg::FN_LN0;
						else
						begin
							up = 1'b1;
							eqd = 1'b0;
							fn = is_tx ? rld_pkg::FN_DP1 : rld_pkg::FN_DP0;
						end
					end
				end
				default:
					en = 1'b0;
			endcase
			if (!s_d.route_valid)
				en = 1'b0;
			// Reversal flips the path but not its equalizer group
			up = up ^ swp;
			s_d.path_en[i] = en;
			s_d.path_up[i] = en & up;
			s_d.path_deq[i] = en & eqd;
			s_d.path_eq[4*i +: 4] = !en ? 4'h0 :
				(eqd ? s_q.deq : s_q.ueq);
			s_d.path_fn[3*i +: 3] = en ? fn : rld_pkg::FN_NONE;
		end

		// Sideband crosspoint
		if (s_d.mode == rld_pkg::MODE_OFF)
			s_d.sbu = rld_pkg::SBU_OPEN;
		else if (ctl_hi)
			s_d.sbu = orient ? rld_pkg::SBU_CROSSED :
				rld_pkg::SBU_STRAIGHT;
		else if (long_low)
			s_d.sbu = rld_pkg::SBU_OPEN;

		// AXI4-Lite write: address and data taken in either order
		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.awready = 1'b0;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.wready = 1'b0;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (!s_q.awready && !s_q.wready && !s_q.bvalid)
		begin
			s_d.bvalid = 1'b1;
			s_d.bresp = rld_pkg::RESP_OKAY;
			if (s_q.aw_addr == rld_pkg::OFS_CONTROL)
			begin
				if (s_q.w_strb[0])
					s_d.reverse_field = s_q.w_data[3:0];
			end
			else
			begin
				void'(read_word(s_q, s_q.aw_addr, rd_hit));
				// Status registers are read-only; writes are ignored
				if (!rd_hit)
					s_d.bresp = rld_pkg::RESP_SLVERR;
			end
		end
		if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready = 1'b1;
		end

		// AXI4-Lite read
		if (s_axi_arvalid && s_q.arready)
		begin
			rd_word = read_word(s_q, s_axi_araddr, rd_hit);
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_word;
			s_d.rresp = rd_hit ? rld_pkg::RESP_OKAY : rld_pkg::RESP_SLVERR;
		end
		else if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.usb_default <= 1'b1;
			s_q.mode <= rld_pkg::MODE_OFF;
			s_q.sbu <= rld_pkg::SBU_OPEN;
			s_q.reverse_field <= rld_pkg::CONTROL_RESET;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign mode = s_q.mode;
	assign sbu_map = s_q.sbu;
	assign path_enable = s_q.path_en;
	assign path_from_upstream = s_q.path_up;
	assign path_eq_downstream = s_q.path_deq;
	assign path_eq_level = s_q.path_eq;
	assign path_function = s_q.path_fn;

endmodule : rld_lane_route_decoder

// *** verification/rld_checker_sva.sv ***
`timescale 1ns/1ps
module rld_checker #(
	parameter int FILTER_TICKS = 3
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins
	input wire logic lane_control_hi,
	input wire logic lane_control_lo,
	input wire logic orientation_flip,
	// Read address and data
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Routing
	input wire rld_pkg::rld_mode_type mode,
	input wire rld_pkg::rld_sbu_type sbu_map,
	input wire logic [3:0] path_enable
);
	logic [15:0] low_q;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	// Raw pin time; the decoder sees it two syncs later, so this over-counts
	always_ff @(posedge aclk)
	begin
		if (!aresetn || lane_control_hi)
			low_q <= 16'h0;
		else if (low_q != 16'hffff)
			low_q <= low_q + 16'h1;
	end
	sequence straight_s;
		(lane_control_hi && !orientation_flip)[*5];
	endsequence
	sequence crossed_s;
		(lane_control_hi && orientation_flip)[*5];
	endsequence
	sequence usb_pins_s;
		(!lane_control_hi && lane_control_lo)[*5];
	endsequence
	chk_aux_straight: assert property (
		straight_s |-> sbu_map == rld_pkg::SBU_STRAIGHT)
		else $error("aux not straight");
	chk_aux_crossed: assert property (
		crossed_s |-> sbu_map == rld_pkg::SBU_CROSSED)
		else $error("aux not crossed");
	chk_usb_mode: assert property (
		usb_pins_s |-> mode == rld_pkg::MODE_USB)
		else $error("usb mode missing");
	chk_usb_pair: assert property (
		mode == rld_pkg::MODE_USB |-> path_enable inside {4'h0, 4'h3, 4'hc})
		else $error("usb not on one pair");
	chk_four_lanes: assert property (
		mode inside {rld_pkg::MODE_ALT4, rld_pkg::MODE_COMBO}
		|-> path_enable inside {4'h0, 4'hf})
		else $error("lanes not all on");
	chk_off_closed: assert property (
		mode == rld_pkg::MODE_OFF
		|-> path_enable == 4'h0 && sbu_map == rld_pkg::SBU_OPEN)
		else $error("power down not closed");
	chk_open_slow: assert property (
		$changed(sbu_map) && sbu_map == rld_pkg::SBU_OPEN
		&& mode != rld_pkg::MODE_OFF |-> low_q >= 16'(FILTER_TICKS * 40))
		else $error("sideband opened early");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
endmodule : rld_checker

bind rld_lane_route_decoder rld_checker #(
	.FILTER_TICKS(FILTER_TICKS)
) chk_u (
	.aclk, .aresetn, .lane_control_hi, .lane_control_lo, .orientation_flip,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mode, .sbu_map,
	.path_enable
);

// *** verification/rld_pd_model.sv ***
`timescale 1ns/1ps
module rld_pd_model (
	// Clock
	input wire logic aclk,
	// Requested pin set and pacing
	input wire logic [5:0] cfg_req,
	input wire logic slow,
	// Configuration pins
	output logic side_select_hi,
	output logic side_select_lo,
	output logic lane_control_hi,
	output logic lane_control_lo,
	output logic orientation_flip,
	output logic path_swap
);
	logic [5:0] stage_q = 6'h0;
	logic [5:0] pins_q = 6'h0;
	// A slow controller lags one cycle, so pins settle late
	always_ff @(posedge aclk)
	begin
		stage_q <= cfg_req;
		pins_q <= slow ? stage_q : cfg_req;
	end
	assign {side_select_hi, side_select_lo, lane_control_hi} = pins_q[5:3];
	assign {lane_control_lo, orientation_flip, path_swap} = pins_q[2:0];
endmodule : rld_pd_model

// *** verification/redriver_lane_route_decoder_tb.sv ***
`timescale 1ns/1ps
module redriver_lane_route_decoder_tb;
	localparam int FT = 3;
	logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
	logic [5:0] cfg_req = 6'h0;
	logic [1:0] interface_select_level = 2'h0;
	logic [3:0] upstream_eq_setting = 4'h0, downstream_eq_setting = 4'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic side_select_hi, side_select_lo, lane_control_hi, lane_control_lo;
	logic orientation_flip, path_swap, dflt, blocked;
	rld_pkg::rld_mode_type mode;
	rld_pkg::rld_sbu_type sbu_map;
	logic [3:0] path_enable, path_from_upstream, path_eq_downstream, ueq, deq;
	logic [15:0] path_eq_level;
	logic [11:0] path_function;
	int fails = 0;
	int samples_checked = 0;

	always #12.5 aclk = ~aclk;
	rld_pd_model pd_u (.aclk, .cfg_req, .slow, .side_select_hi,
		.side_select_lo, .lane_control_hi, .lane_control_lo,
		.orientation_flip, .path_swap);
	rld_lane_route_decoder #(.FILTER_TICKS(FT)) dut_u (.aclk, .aresetn,
		.side_select_hi, .side_select_lo, .lane_control_hi, .lane_control_lo,
		.orientation_flip, .path_swap, .interface_select_level,
		.upstream_eq_setting, .downstream_eq_setting, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode,
		.sbu_map, .path_enable, .path_from_upstream, .path_eq_downstream,
		.path_eq_level, .path_function);
	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	function automatic logic [27:0] exp_route(input logic [5:0] c);
		logic [3:0] um, en, ed, fu;
		logic [15:0] lv;
		// USB pair is pair 1 on the unflipped source; sink or flip moves it
		um = (c[4] ^ c[1]) ? 4'hc : 4'h3;
		en = (c[3:2] == 2'b00) ? (dflt ? um : 4'h0) : (c[3] ? 4'hf : um);
		ed = en & 4'h5 & ((c[5] || !c[3]) ? 4'hf : (c[2] ? um : 4'h0));
		fu = (en & ~ed) ^ (c[0] ? en : 4'h0);
		lv = 16'h0;
		for (int s = 0; s < 4; s++)
			lv[4*s +: 4] = en[s] ? (ed[s] ? deq : ueq) : 4'h0;
		return {en, fu, ed, lv};
	endfunction : exp_route

	task automatic axi(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = !wr;
		w_ok = !wr;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			aw_ok = aw_ok | s_axi_awready;
			w_ok = w_ok | s_axi_wready;
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		if (!wr)
		begin
			do
				@(posedge aclk);
			while (!s_axi_arready);
		end
		s_axi_arvalid <= 1'b0;
		while (!(wr ? s_axi_bvalid : s_axi_rvalid))
			@(posedge aclk);
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi

	task automatic apply(input logic [5:0] c);
		if (cfg_req[2] && !c[2])
			dflt = 1'b0;
		cfg_req <= c;
		repeat (8) @(posedge aclk);
	endtask : apply

	task automatic check_cfg(input logic [5:0] c);
		logic [27:0] e;
		logic [1:0] k;
		e = exp_route(c);
		k = (c[3:2] == 2'b00) ? {1'b0, dflt} : c[3:2];
		if (!blocked)
			cmp(32'(mode), 32'h1 << k);
		cmp(32'(path_enable), blocked ? 32'h0 : 32'(e[27:24]));
		if (!blocked)
			cmp({path_enable, path_from_upstream, path_eq_downstream,
				path_eq_level}, 32'(e));
		if (!c[5] && c[3:2] == 2'b10)
			cmp(32'(path_function), (c[4] ^ c[1]) ? 32'h95a : 32'h6a5);
		if (!blocked && c[5] && c[3:2] == 2'b10)
			cmp(32'(path_function), c[1] ? 32'hdbf : 32'hff6);
		if (!blocked && c[3:2] == 2'b11)
			cmp(32'(path_function), c[5] ? ((c[4] ^ c[1]) ? 32'h276 : 32'hd89)
				: ((c[4] ^ c[1]) ? 32'h25a : 32'h689));
		if (!blocked && k == 2'b01)
			cmp(32'(path_function), (c[4] ^ c[1]) ? 32'h240 : 32'h009);
		if (c[3])
			cmp(32'(sbu_map), c[1] ? 32'(rld_pkg::SBU_CROSSED)
				: 32'(rld_pkg::SBU_STRAIGHT));
		else if (k == 2'b00)
			cmp(32'(sbu_map), 32'(rld_pkg::SBU_OPEN));
	endtask : check_cfg

	task automatic do_reset(input logic [1:0] lvl);
		aresetn <= 1'b0;
		cfg_req <= 6'h0;
		ueq = 4'($urandom);
		deq = 4'($urandom);
		interface_select_level <= lvl;
		upstream_eq_setting <= ueq;
		downstream_eq_setting <= deq;
		dflt = 1'b1;
		blocked = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		// Inputs move after capture; the decode must keep the latched codes
		upstream_eq_setting <= ~ueq;
		downstream_eq_setting <= ~deq;
	endtask : do_reset

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] q;
		logic [1:0] r;
		logic [5:0] c;
		void'($urandom(32'h1bdc));
		do_reset(rld_pkg::LEVEL_F);
		for (int i = 0; i < 160; i++)
		begin
			c = (i < 64) ? 6'(i) : 6'($urandom);
			slow <= 1'($urandom);
			apply(c);
			check_cfg(c);
		end
		$display("test route table done");
		apply(6'b001000);
		apply(6'b000100);
		repeat (FT * 40 - 28) @(posedge aclk);
		cmp(32'(sbu_map), 32'(rld_pkg::SBU_STRAIGHT));
		repeat (140) @(posedge aclk);
		cmp(32'(sbu_map), 32'(rld_pkg::SBU_OPEN));
		apply(6'b001010);
		apply(6'b000110);
		repeat (FT * 40 - 48) @(posedge aclk);
		cmp(32'(sbu_map), 32'(rld_pkg::SBU_CROSSED));
		apply(6'b001010);
		$display("test sideband filter done");
		axi(1'b0, rld_pkg::OFS_CONFIG, 32'h0, q, r);
		cmp(q[9:0], {deq, ueq, rld_pkg::LEVEL_F});
		axi(1'b0, rld_pkg::OFS_STATUS, 32'h0, q, r);
		cmp(q[5:0], {2'(rld_pkg::SBU_CROSSED), 4'(rld_pkg::MODE_ALT4)});
		axi(1'b1, rld_pkg::OFS_STATUS, 32'h0, q, r);
		cmp(r, rld_pkg::RESP_OKAY);
		axi(1'b0, 8'h20, 32'h0, q, r);
		cmp(q, 32'h0);
		cmp(32'(r), 32'(rld_pkg::RESP_SLVERR));
		axi(1'b1, rld_pkg::OFS_CONTROL, 32'h5, q, r);
		axi(1'b0, rld_pkg::OFS_CONTROL, 32'h0, q, r);
		cmp(q[3:0], 4'h5);
		check_cfg(6'b001010);
		$display("test registers done");
		do_reset(rld_pkg::LEVEL_1);
		apply(6'b101000);
		check_cfg(6'b101000);
		axi(1'b1, rld_pkg::OFS_CONTROL, 32'h5, q, r);
		blocked = 1'b1;
		apply(6'b101010);
		check_cfg(6'b101010);
		axi(1'b1, rld_pkg::OFS_CONTROL, 32'hf, q, r);
		blocked = 1'b0;
		apply(6'b101011);
		check_cfg(6'b101011);
		$display("test interface select done");
		summarize();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		summarize();
	end
endmodule : redriver_lane_route_decoder_tb
